// [rtl/mq_flags_pkg.sv]
// Constants shared by the active-queue flag block and its counters.
// Assumes a single hclk domain and a 32-bit AHB-Lite register window.
package mq_flags_pkg;
    // Queue addressing
    localparam int NUM_QUEUES = 4;
    localparam int QIDX_W = 2;
    localparam int QADDR_W = 5;
    localparam int ID_W = 3;
    localparam int DEPTH_DEFAULT = 4096;
    // Pipeline depths of a queue switch, in hclk cycles
    localparam int WR_SEL_STAGES = 2;
    localparam int RD_SEL_STAGES = 3;
    localparam int ID_SYNC_STAGES = 3;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_LEVEL0 = 8'h10;
    // Control fields
    localparam int CTRL_W = 2;
    localparam int CTRL_WR_EN_POS = 0;
    localparam int CTRL_RD_EN_POS = 1;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h3;
    // Status fields
    localparam int ST_FULL_POS = 0;
    localparam int ST_EMPTY_POS = 4;
    localparam int ST_FF_POS = 8;
    localparam int ST_OV_POS = 9;
    localparam int ST_FF_OE_POS = 10;
    localparam int ST_OV_OE_POS = 11;
    localparam int ST_WQ_POS = 16;
    localparam int ST_RQ_POS = 24;
endpackage

// [rtl/queue_occupancy.sv]
// One queue's occupancy counter with full and empty status.
// Assumes increments are refused by the caller while full.
`timescale 1ns/1ns
`default_nettype none
module queue_occupancy
    import mq_flags_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEFAULT,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic inc,
    input wire logic dec,
    output logic [CW-1:0] count,
    output logic full,
    output logic empty
);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    generate
        if (DEPTH < 2) begin : g_bad_depth
            $error("queue_occupancy needs DEPTH of at least 2");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Count tracks writes and reads in any queue, selected or not
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (clk_en) begin
            if (inc && !dec) begin
                count <= count + CW'(1);
            end else if (dec && !inc) begin
                count <= count - CW'(1);
            end
        end
    end

    // Status for the active flags and the status register
    assign full = (count == DEPTH_C);
    assign empty = (count == '0);
endmodule
`default_nettype wire

// [rtl/multi_queue_active_flags.sv]
// Active-queue full flag and output-valid flag for a four-queue device.
// Assumes queue controller logic on hclk and static identity pins.
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Per-queue full status, selected one on flag
// - Full flag follows new queue at second edge
// - Writes to new queue from third edge
// - Full flag changes only on clock edge
// - Reads update full status of unselected queues
// - Full flag driven only on identity match
// - Full flag released when no queue selected
// - Full flag follows switches within device
// - Valid flag updates with output register load
// - Per-queue empty status, selected one shown
// - Last word read makes flag invalid
// - New read queue appears three cycles later
// - Valid flag changes only on clock edge
// - Writes clear empty status of unselected queues
// - Valid flag driven only on identity match
// - Valid flag released when no queue selected
// - Valid flag follows switches within device
// - Five-bit address, two queue bits, three device
// - Full flag low means queue full
module multi_queue_active_flags
    import mq_flags_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEFAULT
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic write_select_strobe,
    input wire logic [QADDR_W-1:0] write_queue_select_bus,
    input wire logic write_enable_n,
    input wire logic read_select_strobe,
    input wire logic [QADDR_W-1:0] read_queue_select_bus,
    input wire logic read_enable_n,
    input wire logic chip_identity_bit0,
    input wire logic chip_identity_bit1,
    input wire logic chip_identity_bit2,
    output logic active_queue_full_n,
    output logic active_queue_full_oe,
    output logic output_word_valid_n,
    output logic output_word_valid_oe,
    output logic [QIDX_W-1:0] output_word_queue
);
    localparam int CW = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || DEPTH > 65535) begin : g_bad_depth
            $error("multi_queue_active_flags supports DEPTH 2 to 65535");
        end
    endgenerate

    logic [ID_W-1:0] id_sync [ID_SYNC_STAGES];
    logic [ID_W-1:0] chip_id_reg;
    logic [QADDR_W-1:0] wsel_pipe [WR_SEL_STAGES];
    logic [QADDR_W-1:0] rsel_pipe [RD_SEL_STAGES];
    logic [QADDR_W-1:0] wq_active_reg;
    logic [QADDR_W-1:0] rq_active_reg;
    logic [CTRL_W-1:0] ctrl_reg;
    logic [CTRL_W-1:0] ctrl_view;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rd_word;
    logic addr_phase;
    logic [CW-1:0] q_count [NUM_QUEUES];
    logic [NUM_QUEUES-1:0] q_full;
    logic [NUM_QUEUES-1:0] q_empty;
    logic [NUM_QUEUES-1:0] q_inc;
    logic [NUM_QUEUES-1:0] q_dec;
    logic wr_match;
    logic wr_take;
    logic [QIDX_W-1:0] wq_idx;
    logic [QADDR_W-1:0] wsel_last;
    logic act_match;
    logic [QIDX_W-1:0] act_q;
    logic rd_take;
    logic [QADDR_W-1:0] rsel_last;
    logic [QIDX_W-1:0] tgt_q;
    logic tgt_match;
    logic held_same;
    logic load_ok;
    logic reload;

    // Device is addressed when the top address bits carry its identity
    function automatic logic dev_match(input logic [QADDR_W-1:0] a,
                                       input logic [ID_W-1:0] id);
        return a[QADDR_W-1:QIDX_W] == id;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Identity pins: three stages, accepted once the last two agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < ID_SYNC_STAGES; i++) begin
                id_sync[i] <= '0;
            end
            chip_id_reg <= '0;
        end else if (clk_en) begin
            id_sync[0] <= {chip_identity_bit2, chip_identity_bit1, chip_identity_bit0};
            for (int i = 1; i < ID_SYNC_STAGES; i++) begin
                id_sync[i] <= id_sync[i-1];
            end
            if (id_sync[ID_SYNC_STAGES-2] == id_sync[ID_SYNC_STAGES-1]) begin
                chip_id_reg <= id_sync[ID_SYNC_STAGES-1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-queue counters; any queue moves, selected or not
    generate
        for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_queue
            assign q_inc[q] = wr_take && (wq_idx == QIDX_W'(q));
            assign q_dec[q] = rd_take && (act_q == QIDX_W'(q));
            queue_occupancy #(
                .DEPTH(DEPTH),
                .CW(CW)
            ) u_occ (
                .hclk(hclk),
                .hresetn(hresetn),
                .clk_en(clk_en),
                .inc(q_inc[q]),
                .dec(q_dec[q]),
                .count(q_count[q]),
                .full(q_full[q]),
                .empty(q_empty[q])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Write queue selection pipeline
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < WR_SEL_STAGES; i++) begin
                wsel_pipe[i] <= '0;
            end
            wq_active_reg <= '0;
        end else if (clk_en) begin
            if (write_select_strobe) begin
                wsel_pipe[0] <= write_queue_select_bus;
            end
            for (int i = 1; i < WR_SEL_STAGES; i++) begin
                wsel_pipe[i] <= wsel_pipe[i-1];
            end
            // Writes switch one edge after the flag does
            wq_active_reg <= wsel_pipe[WR_SEL_STAGES-1];
        end
    end

    assign wsel_last = wsel_pipe[WR_SEL_STAGES-1];
    assign wq_idx = wq_active_reg[QIDX_W-1:0];
    assign wr_match = dev_match(wq_active_reg, chip_id_reg);
    // Writes to a full queue are refused, not just discouraged
    assign wr_take = !write_enable_n && wr_match && ctrl_reg[CTRL_WR_EN_POS]
                     && !q_full[wq_idx];

    ////////////////////////////////////////////////////////////////////////////////
    // Full flag: registered from the pipeline's last stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_queue_full_n <= 1'b1;
            active_queue_full_oe <= 1'b0;
        end else if (clk_en) begin
            // Undriven level kept high so a released line idles not-full
            active_queue_full_n <= !(dev_match(wsel_last, chip_id_reg)
                                     && q_full[wsel_last[QIDX_W-1:0]]);
            active_queue_full_oe <= dev_match(wsel_last, chip_id_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read queue selection pipeline
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < RD_SEL_STAGES; i++) begin
                rsel_pipe[i] <= '0;
            end
            rq_active_reg <= '0;
        end else if (clk_en) begin
            if (read_select_strobe) begin
                rsel_pipe[0] <= read_queue_select_bus;
            end
            for (int i = 1; i < RD_SEL_STAGES; i++) begin
                rsel_pipe[i] <= rsel_pipe[i-1];
            end
            rq_active_reg <= rsel_pipe[RD_SEL_STAGES-1];
        end
    end

    // The word in the output register stays counted in its queue until
    // it is read, so an unread word survives a switch away from it.
    assign act_match = dev_match(rq_active_reg, chip_id_reg);
    assign act_q = rq_active_reg[QIDX_W-1:0];
    assign rd_take = !output_word_valid_n && !read_enable_n && act_match;
    assign rsel_last = rsel_pipe[RD_SEL_STAGES-1];
    assign tgt_q = rsel_last[QIDX_W-1:0];
    assign tgt_match = dev_match(rsel_last, chip_id_reg);
    assign held_same = !output_word_valid_n && act_match && (act_q == tgt_q);
    assign load_ok = tgt_match && ctrl_reg[CTRL_RD_EN_POS]
                     && (q_count[tgt_q] > CW'(held_same));
    // Reload on a switch, on a read, or while the register holds nothing
    assign reload = (rsel_last != rq_active_reg) || output_word_valid_n || rd_take;

    ////////////////////////////////////////////////////////////////////////////////
    // Output register status: valid flag moves with each load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_word_valid_n <= 1'b1;
            output_word_valid_oe <= 1'b0;
            output_word_queue <= '0;
        end else if (clk_en) begin
            if (reload) begin
                output_word_valid_n <= !load_ok;
                output_word_queue <= tgt_q;
            end
            output_word_valid_oe <= tgt_match;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY
    assign addr_phase = hsel && htrans[1] && hready;

    // Write data phase lands one edge after the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else if (clk_en) begin
            wr_pend_reg <= addr_phase && hwrite && (haddr[31:8] == 24'h000000);
            wr_addr_reg <= haddr[7:0];
        end
    end

    // Control register; port enables gate writes and loads
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (clk_en) begin
            if (wr_pend_reg && wr_addr_reg == ADDR_CTRL) begin
                ctrl_reg <= hwdata[CTRL_W-1:0];
            end
        end
    end

    // Forward a write still in its data phase to a back-to-back read
    assign ctrl_view = (wr_pend_reg && wr_addr_reg == ADDR_CTRL) ?
                       hwdata[CTRL_W-1:0] : ctrl_reg;

    // Read decode; unmapped addresses read as zero
    always_comb begin
        rd_word = '0;
        if (haddr[31:8] != 24'h000000) begin
            rd_word = '0;
        end else if (haddr[7:0] == ADDR_CTRL) begin
            rd_word[CTRL_W-1:0] = ctrl_view;
        end else if (haddr[7:0] == ADDR_STATUS) begin
            rd_word[ST_FULL_POS +: NUM_QUEUES] = q_full;
            rd_word[ST_EMPTY_POS +: NUM_QUEUES] = q_empty;
            rd_word[ST_FF_POS] = active_queue_full_n;
            rd_word[ST_OV_POS] = output_word_valid_n;
            rd_word[ST_FF_OE_POS] = active_queue_full_oe;
            rd_word[ST_OV_OE_POS] = output_word_valid_oe;
            rd_word[ST_WQ_POS +: QADDR_W] = wq_active_reg;
            rd_word[ST_RQ_POS +: QADDR_W] = rq_active_reg;
        end else if (haddr[7:4] == ADDR_LEVEL0[7:4] && haddr[1:0] == 2'h0) begin
            rd_word[CW-1:0] = q_count[haddr[3:2]];
        end
    end

    // Read data and handshake outputs, all registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            if (addr_phase && !hwrite) begin
                hrdata <= rd_word;
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [tb/mq_flags_monitor.sv]
// Checker for the active-queue flag block, bound to its top module.
// Assumes one clock, hresetn async active low, static identity pins.
`timescale 1ns/1ns
`default_nettype none
module mq_flags_monitor
    import mq_flags_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic write_select_strobe,
    input wire logic [QADDR_W-1:0] write_queue_select_bus,
    input wire logic read_select_strobe,
    input wire logic [QADDR_W-1:0] read_queue_select_bus,
    input wire logic chip_identity_bit0,
    input wire logic chip_identity_bit1,
    input wire logic chip_identity_bit2,
    input wire logic active_queue_full_n,
    input wire logic active_queue_full_oe,
    input wire logic output_word_valid_oe,
    input wire logic [QIDX_W-1:0] output_word_queue
);
    logic [ID_W-1:0] chip_id;
    logic wr_here;
    logic rd_here;
    // Address match against the static identity pins
    assign chip_id = {chip_identity_bit2, chip_identity_bit1, chip_identity_bit0};
    assign wr_here = write_queue_select_bus[4:2] == chip_id;
    assign rd_here = read_queue_select_bus[4:2] == chip_id;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Quiet windows before a strobe keep older switches out of the picture
    full_sel_lat_a: assert property (write_select_strobe |-> ##3
        active_queue_full_oe == $past(wr_here, 3)) else $error("full drive wrong after select");
    full_sel_hold_a: assert property (!write_select_strobe[*2] ##1 write_select_strobe
        |-> ##1 $stable(active_queue_full_oe)[*2]) else $error("full drive moved too early");
    full_idle_high_a: assert property (!active_queue_full_oe |-> active_queue_full_n)
        else $error("full level low while released");
    full_keep_a: assert property (!write_select_strobe[*2] ##1 (write_select_strobe
        && wr_here && active_queue_full_oe) |-> active_queue_full_oe[*4])
        else $error("full drive dropped on local switch");
    rd_sel_lat_a: assert property (read_select_strobe |-> ##4
        output_word_valid_oe == $past(rd_here, 4)) else $error("valid drive wrong after select");
    rd_queue_a: assert property (read_select_strobe && rd_here |-> ##4
        output_word_queue == $past(read_queue_select_bus[1:0], 4))
        else $error("output queue wrong after select");
    rd_hold_a: assert property (!read_select_strobe[*3] ##1 read_select_strobe
        |-> ##1 $stable(output_word_queue)[*3]) else $error("output queue moved too early");
    valid_keep_a: assert property (!read_select_strobe[*3] ##1 (read_select_strobe
        && rd_here && output_word_valid_oe) |-> output_word_valid_oe[*5])
        else $error("valid drive dropped on local switch");
endmodule
bind multi_queue_active_flags mq_flags_monitor mq_flags_monitor_i (
    .hclk, .hresetn, .write_select_strobe, .write_queue_select_bus, .read_select_strobe,
    .read_queue_select_bus, .chip_identity_bit0, .chip_identity_bit1, .chip_identity_bit2,
    .active_queue_full_n, .active_queue_full_oe, .output_word_valid_oe, .output_word_queue
);
`default_nettype wire

// [tb/queue_ctl.sv]
// Model of the system controller on the queue write and read ports.
// Assumes tasks are called from the bench just after a rising hclk edge.
`timescale 1ns/1ns
`default_nettype none
module queue_ctl
    import mq_flags_pkg::*;
(
    input wire logic hclk,
    input wire logic full_line,
    output logic wsel,
    output logic [QADDR_W-1:0] wbus,
    output logic wen_n,
    output logic rsel,
    output logic [QADDR_W-1:0] rbus,
    output logic ren_n
);
    // Idle levels at time zero
    initial begin
        wsel = 1'b0;
        wbus = '0;
        wen_n = 1'b1;
        rsel = 1'b0;
        rbus = '0;
        ren_n = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One device addressed per port; bus scrambled once the strobe is gone
    task automatic sel(input logic rd, input logic [QADDR_W-1:0] a);
        @(posedge hclk);
        if (rd) begin
            rsel <= 1'b1;
            rbus <= a;
        end else begin
            wsel <= 1'b1;
            wbus <= a;
        end
        @(posedge hclk);
        rsel <= 1'b0;
        wsel <= 1'b0;
        if (rd) rbus <= ~a;
        else wbus <= ~a;
        @(posedge hclk);
    endtask
    // Word transfers; caller waits past the select pipe before writing
    task automatic xfer(input logic rd, input int n);
        repeat (n) begin
            @(posedge hclk);
            if (rd) ren_n <= 1'b0;
            else wen_n <= ~full_line;
        end
        @(posedge hclk);
        ren_n <= 1'b1;
        wen_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// [tb/multi_queue_active_flags_tb_top.sv]
// Self-checking bench for the active-queue full and output-valid flags.
// Assumes one device with a fixed identity and shallow queues.
`timescale 1ns/1ns
`default_nettype none
module multi_queue_active_flags_tb_top
    import mq_flags_pkg::*;
;
    localparam int DEPTH_SIM = 4;
    localparam logic [ID_W-1:0] MY_ID = 3'h1; // Arbitrary identity value
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic clk_en = 1'b1;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, wsel, rsel, wen_n, ren_n;
    logic [31:0] hrdata, rd;
    logic [QADDR_W-1:0] wbus, rbus;
    logic full_n, full_oe, valid_n, valid_oe, full_line, valid_line;
    logic [QIDX_W-1:0] owq;
    int error_cnt = 0;
    int tests_run = 0;
    // Clock and shared flag lines, pulled up when nobody drives
    always #50 hclk = ~hclk;
    assign full_line = full_oe ? full_n : 1'b1;
    assign valid_line = valid_oe ? valid_n : 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    multi_queue_active_flags #(.DEPTH(DEPTH_SIM)) multi_queue_active_flags_i (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .write_select_strobe(wsel),
        .write_queue_select_bus(wbus), .write_enable_n(wen_n), .read_select_strobe(rsel),
        .read_queue_select_bus(rbus), .read_enable_n(ren_n), .chip_identity_bit0(MY_ID[0]),
        .chip_identity_bit1(MY_ID[1]), .chip_identity_bit2(MY_ID[2]),
        .active_queue_full_n(full_n), .active_queue_full_oe(full_oe),
        .output_word_valid_n(valid_n), .output_word_valid_oe(valid_oe), .output_word_queue(owq)
    );
    queue_ctl queue_ctl_i (.hclk(hclk), .full_line(full_line), .wsel(wsel), .wbus(wbus),
        .wen_n(wen_n), .rsel(rsel), .rbus(rbus), .ren_n(ren_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %0h want %0h", $time, what, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Single word transfer; waits on hready, no fixed latency assumed
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Address 0 after reset is another device: both flags released
    task automatic t_reset_regs();
        #1 check(full_oe, 0, "full drive idle");
        check(valid_oe, 0, "valid drive idle");
        ahb(1'b0, 32'(ADDR_CTRL), 0);
        check(rd, 32'(CTRL_RESET), "ctrl reset");
        check(hresp, 0, "okay response");
        ahb(1'b1, 32'(ADDR_CTRL), 32'h1);
        ahb(1'b0, 32'(ADDR_CTRL), 0);
        check(rd, 32'h1, "ctrl readback");
        ahb(1'b1, 32'(ADDR_CTRL), 32'h3);
        ahb(1'b0, 32'h80, 0);
        check(rd, 0, "unmapped read");
    endtask
    // Fill q0, then switch to q1 inside the device
    task automatic t_fill();
        queue_ctl_i.sel(1'b0, {MY_ID, 2'd0});
        #1 check(full_oe, 0, "full drive early");
        @(posedge hclk) #1 check(full_oe, 1, "full drive q0");
        check(full_line, 1, "q0 not full");
        queue_ctl_i.xfer(1'b0, DEPTH_SIM);
        @(posedge hclk) #1 check(full_line, 0, "q0 full");
        queue_ctl_i.sel(1'b0, {MY_ID, 2'd1});
        #1 check(full_line, 0, "old queue still shown");
        @(posedge hclk) #1 check(full_line, 1, "q1 not full");
    endtask
    // Read q0: switch latency, read frees the unselected q0, drain to empty
    task automatic t_read();
        queue_ctl_i.sel(1'b1, {MY_ID, 2'd0});
        @(posedge hclk) #1 check(valid_oe, 0, "valid drive early");
        @(posedge hclk) #1 check(valid_line, 0, "q0 word valid");
        check(owq, 0, "output queue q0");
        queue_ctl_i.xfer(1'b1, 1);
        queue_ctl_i.sel(1'b0, {MY_ID, 2'd0});
        @(posedge hclk) #1 check(full_line, 1, "read frees q0");
        queue_ctl_i.xfer(1'b1, DEPTH_SIM - 1);
        #1 check(valid_line, 1, "drained");
        ahb(1'b0, 32'(ADDR_LEVEL0), 0);
        check(rd, 0, "q0 level");
    endtask
    // Write q2 while the read port sits on empty q0, then switch the read port to q2
    task automatic t_other_queue();
        queue_ctl_i.sel(1'b0, {MY_ID, 2'd2});
        // Let the new queue's flag settle so the first write decision sees it
        @(posedge hclk);
        queue_ctl_i.xfer(1'b0, 2);
        #1 check(valid_line, 1, "q0 stays empty");
        queue_ctl_i.sel(1'b1, {MY_ID, 2'd2});
        repeat (2) @(posedge hclk);
        #1 check(valid_line, 0, "q2 valid");
        check(owq, 2, "output queue q2");
        // Clock enable low: a write offered meanwhile must not land in q2
        @(posedge hclk) clk_en <= 1'b0;
        queue_ctl_i.xfer(1'b0, 1);
        @(posedge hclk) clk_en <= 1'b1;
        ahb(1'b0, 32'(ADDR_LEVEL0) + 32'h8, 0);
        check(rd, 2, "frozen write dropped");
    endtask
    // Both ports move to another device
    task automatic t_other_dev();
        queue_ctl_i.sel(1'b0, {MY_ID + 3'h1, 2'd0});
        @(posedge hclk) #1 check(full_oe, 0, "full released");
        queue_ctl_i.sel(1'b1, {MY_ID + 3'h1, 2'd0});
        repeat (2) @(posedge hclk);
        #1 check(valid_oe, 0, "valid released");
        // Status: q0, q1, q3 empty, both flags released high, both ports on device 2
        ahb(1'b0, 32'(ADDR_STATUS), 0);
        check(rd, 32'h0808_03b0, "status word");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; identity needs a few edges to settle after reset
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        t_reset_regs();
        t_fill();
        t_read();
        t_other_queue();
        t_other_dev();
        end_of_test();
    end
    // Watchdog, far beyond the roughly ninety cycles the run needs
    initial begin
        #(3000 * 100);
        error_cnt++;
        end_of_test();
    end
endmodule
`default_nettype wire
